// *** btn_sync.sv ***
/*
  Two-stage synchroniser for the button pins.
  Assumes pins are asynchronous levels; no debounce beyond the hold timer.
*/
`timescale 1ns/1ps
`default_nettype none
module btn_sync #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st;
  sync_st_t n;

  // first stage feeds only the second
  always_comb
  begin
    n.s1 = async_in;
    n.s2 = st.s1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= n;
  end

  assign sync_out = st.s2;
endmodule : btn_sync
`default_nettype wire

// *** hold_timer.sv ***
/*
  Hold-duration timer counting half-second units since the last restart.
  Assumes restart_in comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter int unsigned HALF_CYC = scfg_pkg::HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic restart_in,
  output logic [7:0] halves_out
);
  localparam int CW = $clog2(HALF_CYC) + 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [7:0] halves;
  } tmr_st_t;

  tmr_st_t st;
  tmr_st_t n;

  // prescale to half seconds, saturate the unit count
  always_comb
  begin
    n = st;
    if (restart_in)
      n = '0;
    else if (st.cyc == CYC_LAST)
    begin
      n.cyc = '0;
      if (st.halves != 8'hFF)
        n.halves = st.halves + 8'h01;
    end
    else
      n.cyc = st.cyc + CW'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= n;
  end

  assign halves_out = st.halves;
endmodule : hold_timer
`default_nettype wire

// *** scfg_operator.sv ***
/*
  Behavioural model of the operator at the button pins: timed presses,
  pulse trains and the configuration hold patterns.
  Assumes one clock, levels changed right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module scfg_operator #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic clk_in,
  input wire logic motor_up_in,
  input wire logic motor_down_in,
  output var scfg_pkg::btn_t btn_out,
  output var logic stuck_out
);
  localparam logic [3:0] MP = 4'h8;
  localparam logic [3:0] CP = 4'h4;
  localparam logic [3:0] UP = 4'h2;

  // released pins read low
  initial
  begin
    btn_out = scfg_pkg::btn_t'(4'h0);
    stuck_out = 1'b0;
  end

  // apply one button combination for a number of half seconds
  task automatic hold(input logic [3:0] b, input int halves);
    @(posedge clk_in);
    btn_out <= scfg_pkg::btn_t'(b);
    repeat (halves * HALF_CYC) @(posedge clk_in);
  endtask : hold

  // wait with a bound until the motor stands still
  task automatic wait_stopped();
    int n;
    n = 0;
    while ((motor_up_in !== 1'b0 || motor_down_in !== 1'b0) && n < 1000)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 1000)
      stuck_out = 1'b1;
  endtask : wait_stopped

  // motor button, then cord button, then direction, all held
  task automatic factory_hold(input int halves);
    wait_stopped();
    hold(MP, 1);
    hold(MP | CP, 1);
    hold(MP | CP | UP, halves);
    hold(4'h0, 2);
  endtask : factory_hold

  // primary held, short pulses on the other line, last press held
  task automatic ep_prog(input logic [3:0] prim, input logic [3:0] sec, input int n,
                         input int last_halves);
    hold(prim, 1);
    repeat (n)
    begin
      hold(prim | sec, 1);
      hold(prim, 1);
    end
    hold(prim | sec, last_halves);
  endtask : ep_prog
endmodule : scfg_operator
`default_nettype wire

// *** scfg_pkg.sv ***
/*
  Shared constants and types of the shutter motor configuration interpreter:
  time base figures, hold thresholds, register map, button and record types.
  Assumes a single 125 MHz clock domain and one flat 16-bit register port with a 2-bit address.

// Behaviour
// - factory reset clears ends, enables all features
// - reset: motor prog, cord prog, direction, 10s
// - after 10s load defaults, jog up then down
// - after defaults, end store empty, learning available
// - cord prog plus direction 10s toggles reversing
// - reversing toggle confirmed by one brief jog
// - hold to 20s also toggles length compensation
// - compensation toggle confirmed by second brief jog
// - up held drives up until upper end
// - upper program: hold up, two down pulses, hold
// - programming: both released stops, stores position
// - lower program mirrors upper with inputs swapped
// - button reset: down at end, five up pulses
// - shortly after sixth hold, defaults and up-down jog
// - end points kept in non-volatile storage
*/
package scfg_pkg;
  // time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HALF_SEC_MS = 500;
  localparam int unsigned HALF_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int unsigned CFG_HOLD_S = 10;
  localparam int unsigned COMP_HOLD_S = 20;
  // thresholds in half-second units and press counts
  localparam logic [7:0] RST_HALVES = 8'(CFG_HOLD_S * 2);
  localparam logic [7:0] COMP_HALVES = 8'(COMP_HOLD_S * 2);
  localparam logic [7:0] SHORT_HALVES = 8'h02;
  localparam logic [7:0] GAP_HALVES = 8'h02;
  localparam logic [7:0] JOG_HALVES = 8'h01;
  localparam logic [7:0] FR_DELAY_HALVES = 8'h01;
  localparam logic [2:0] EP_PRESSES = 3'h3;
  localparam logic [2:0] FR_PRESSES = 3'h6;
  // register map
  localparam logic [1:0] REG_SETTINGS = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_UPPER = 2'h2;
  localparam logic [1:0] REG_LOWER = 2'h3;
  localparam int SET_AUTO_B = 0;
  localparam int SET_OBST_B = 1;
  localparam int SET_BLOCK_B = 2;
  localparam int SET_COMP_B = 3;
  localparam int ST_UPPER_V_B = 0;
  localparam int ST_LOWER_V_B = 1;
  localparam int ST_MUP_B = 2;
  localparam int ST_MDN_B = 3;
  localparam int ST_BUSY_B = 4;
  localparam logic [3:0] DEF_SETTINGS = 4'hF;

  typedef struct packed {
    logic motor_prog;
    logic cord_prog;
    logic up;
    logic down;
  } btn_t;

  typedef struct packed {
    logic [15:0] upper_pos;
    logic [15:0] lower_pos;
    logic upper_valid;
    logic lower_valid;
    logic comp;
    logic rev_block;
    logic rev_obst;
    logic auto_adj;
  } nv_rec_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [3:0] {
    S_LOAD, S_IDLE, S_RST_HOLD, S_CFG_HOLD, S_ARM,
    S_EP_RUN, S_FR_WAIT, S_ACK_UP, S_ACK_DOWN, S_RELEASE
  } state_t;
endpackage : scfg_pkg

// *** shutter_cfg_ctrl.sv ***
/*
  Configuration command interpreter of a tubular shutter motor: button
  pattern and hold decoding, setting toggles, end point programming,
  factory reset and acknowledge jogs.
  Assumes pos_in and nv_rd_in come from same-clock logic, button pins are
  asynchronous, and the non-volatile store accepts nv_wr_out pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module shutter_cfg_ctrl #(
  parameter int unsigned HALF_CYC = scfg_pkg::HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire scfg_pkg::btn_t btn_in,
  input wire logic [15:0] pos_in,
  input wire scfg_pkg::nv_rec_t nv_rd_in,
  input wire scfg_pkg::reg_req_t reg_in,
  output logic [15:0] reg_rdata_out,
  output logic nv_wr_out,
  output scfg_pkg::nv_rec_t nv_wr_data_out,
  output logic motor_up_out,
  output logic motor_down_out,
  output logic auto_adjust_out,
  output logic rev_obstacle_out,
  output logic rev_blockage_out,
  output logic comp_out
);
  typedef struct packed {
    scfg_pkg::state_t state;
    scfg_pkg::nv_rec_t rec;
    scfg_pkg::btn_t prev;
    logic motor_up;
    logic motor_down;
    logic nv_wr;
    logic [15:0] rdata;
    logic primary_up;
    logic [2:0] presses;
    logic [2:0] target;
    logic tog1;
    logic tog2;
    logic motor_first;
  } ctrl_st_t;

  ctrl_st_t st;
  ctrl_st_t n;
  logic [3:0] b_vec;
  scfg_pkg::btn_t b;
  logic [7:0] halves;
  logic restart;
  logic at_upper;
  logic at_lower;
  logic any_dir;
  logic no_prog;
  logic prim;
  logic other;
  logic other_prev;
  logic rst_ok;
  logic cfg_ok;

  // factory defaults: ends forgotten, all features on
  function automatic scfg_pkg::nv_rec_t load_defaults(input scfg_pkg::nv_rec_t r);
    scfg_pkg::nv_rec_t d;
    d = r;
    d.upper_valid = 1'b0;
    d.lower_valid = 1'b0;
    d.auto_adj = scfg_pkg::DEF_SETTINGS[scfg_pkg::SET_AUTO_B];
    d.rev_obst = scfg_pkg::DEF_SETTINGS[scfg_pkg::SET_OBST_B];
    d.rev_block = scfg_pkg::DEF_SETTINGS[scfg_pkg::SET_BLOCK_B];
    d.comp = scfg_pkg::DEF_SETTINGS[scfg_pkg::SET_COMP_B];
    return d;
  endfunction : load_defaults

  btn_sync #(
    .W(4)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(btn_in),
    .sync_out(b_vec)
  );

  hold_timer #(
    .HALF_CYC(HALF_CYC)
  ) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .restart_in(restart),
    .halves_out(halves)
  );

  // input qualifiers
  always_comb
  begin
    b = scfg_pkg::btn_t'(b_vec);
    at_upper = st.rec.upper_valid && (pos_in >= st.rec.upper_pos);
    at_lower = st.rec.lower_valid && (pos_in <= st.rec.lower_pos);
    any_dir = b.up || b.down;
    no_prog = !b.motor_prog && !b.cord_prog;
    prim = st.primary_up ? b.up : b.down;
    other = st.primary_up ? b.down : b.up;
    other_prev = st.primary_up ? st.prev.down : st.prev.up;
    rst_ok = b.motor_prog && b.cord_prog && any_dir;
    cfg_ok = b.cord_prog && !b.motor_prog && any_dir;
  end

  // next state of the whole interpreter
  always_comb
  begin
    n = st;
    n.prev = b;
    n.motor_up = 1'b0;
    n.motor_down = 1'b0;
    n.nv_wr = 1'b0;
    n.rdata = 16'h0000;
    // remember that the motor button came before the cord button
    if (!b.motor_prog)
      n.motor_first = 1'b0;
    else if (!b.cord_prog)
      n.motor_first = 1'b1;
    // software settings write, overridden by a toggle in the same cycle
    if (reg_in.wr && reg_in.addr == scfg_pkg::REG_SETTINGS)
    begin
      n.rec.auto_adj = reg_in.wdata[scfg_pkg::SET_AUTO_B];
      n.rec.rev_obst = reg_in.wdata[scfg_pkg::SET_OBST_B];
      n.rec.rev_block = reg_in.wdata[scfg_pkg::SET_BLOCK_B];
      n.rec.comp = reg_in.wdata[scfg_pkg::SET_COMP_B];
      n.nv_wr = 1'b1;
    end
    // read data for the next cycle only
    if (reg_in.rd)
    begin
      unique case (reg_in.addr)
        scfg_pkg::REG_SETTINGS:
        begin
          n.rdata[scfg_pkg::SET_AUTO_B] = st.rec.auto_adj;
          n.rdata[scfg_pkg::SET_OBST_B] = st.rec.rev_obst;
          n.rdata[scfg_pkg::SET_BLOCK_B] = st.rec.rev_block;
          n.rdata[scfg_pkg::SET_COMP_B] = st.rec.comp;
        end
        scfg_pkg::REG_STATUS:
        begin
          n.rdata[scfg_pkg::ST_UPPER_V_B] = st.rec.upper_valid;
          n.rdata[scfg_pkg::ST_LOWER_V_B] = st.rec.lower_valid;
          n.rdata[scfg_pkg::ST_MUP_B] = st.motor_up;
          n.rdata[scfg_pkg::ST_MDN_B] = st.motor_down;
          n.rdata[scfg_pkg::ST_BUSY_B] = (st.state != scfg_pkg::S_IDLE);
        end
        scfg_pkg::REG_UPPER:
          n.rdata = st.rec.upper_pos;
        scfg_pkg::REG_LOWER:
          n.rdata = st.rec.lower_pos;
      endcase
    end
    unique case (st.state)
      // pick up the stored record after power-up
      scfg_pkg::S_LOAD:
      begin
        n.rec = nv_rd_in;
        n.state = scfg_pkg::S_IDLE;
      end
      scfg_pkg::S_IDLE:
      begin
        if (rst_ok && st.motor_first)
          n.state = scfg_pkg::S_RST_HOLD;
        else if (cfg_ok && (b.up ^ b.down))
        begin
          n.state = scfg_pkg::S_CFG_HOLD;
          n.tog1 = 1'b0;
          n.tog2 = 1'b0;
        end
        else if (no_prog && b.up && b.down && (st.prev.up ^ st.prev.down))
        begin
          // second direction joins a held one: pattern starts
          n.state = scfg_pkg::S_ARM;
          n.primary_up = st.prev.up;
          n.presses = 3'h0;
          n.target = (!st.prev.up && at_lower) ? scfg_pkg::FR_PRESSES
                                                : scfg_pkg::EP_PRESSES;
        end
        else if (no_prog && b.up && !b.down)
          n.motor_up = !at_upper;
        else if (no_prog && b.down && !b.up)
          n.motor_down = !at_lower;
      end
      // all three held until the reset hold expires
      scfg_pkg::S_RST_HOLD:
      begin
        if (!rst_ok)
          n.state = scfg_pkg::S_RELEASE;
        else if (halves >= scfg_pkg::RST_HALVES)
        begin
          n.rec = load_defaults(st.rec);
          n.nv_wr = 1'b1;
          n.state = scfg_pkg::S_ACK_UP;
        end
      end
      // cord button plus direction: toggles at 10 s and 20 s
      scfg_pkg::S_CFG_HOLD:
      begin
        if (!cfg_ok)
          n.state = scfg_pkg::S_RELEASE;
        else
        begin
          if (halves >= scfg_pkg::RST_HALVES && !st.tog1)
          begin
            n.rec.rev_obst = !st.rec.rev_obst;
            n.tog1 = 1'b1;
            n.nv_wr = 1'b1;
          end
          if (halves >= scfg_pkg::COMP_HALVES && !st.tog2)
          begin
            n.rec.comp = !st.rec.comp;
            n.tog2 = 1'b1;
            n.nv_wr = 1'b1;
          end
          n.motor_up = (halves == scfg_pkg::RST_HALVES)
                    || (halves == scfg_pkg::COMP_HALVES);
        end
      end
      // count short pulses on the other input
      scfg_pkg::S_ARM:
      begin
        if (!prim || !no_prog)
          n.state = scfg_pkg::S_RELEASE;
        else if (!other && other_prev)
        begin
          if (halves < scfg_pkg::SHORT_HALVES)
            n.presses = st.presses + 3'h1;
          else
            n.state = scfg_pkg::S_RELEASE;
        end
        else if (!other && halves >= scfg_pkg::GAP_HALVES)
          n.state = scfg_pkg::S_RELEASE;
        else if (other && !other_prev)
          n.state = scfg_pkg::S_ARM;
        else if (other && halves >= scfg_pkg::SHORT_HALVES)
        begin
          if (st.presses != st.target - 3'h1)
            n.state = scfg_pkg::S_RELEASE;
          else if (st.target == scfg_pkg::FR_PRESSES)
            n.state = scfg_pkg::S_FR_WAIT;
          else
            n.state = scfg_pkg::S_EP_RUN;
        end
      end
      // operator-controlled run; stop and store when both released
      scfg_pkg::S_EP_RUN:
      begin
        if (!b.up && !b.down)
        begin
          if (st.primary_up)
          begin
            n.rec.upper_pos = pos_in;
            n.rec.upper_valid = 1'b1;
          end
          else
          begin
            n.rec.lower_pos = pos_in;
            n.rec.lower_valid = 1'b1;
          end
          n.nv_wr = 1'b1;
          n.state = scfg_pkg::S_IDLE;
        end
        else
        begin
          n.motor_up = st.primary_up;
          n.motor_down = !st.primary_up;
        end
      end
      // short pause after the sixth hold
      scfg_pkg::S_FR_WAIT:
      begin
        if (halves >= scfg_pkg::FR_DELAY_HALVES)
        begin
          n.rec = load_defaults(st.rec);
          n.nv_wr = 1'b1;
          n.state = scfg_pkg::S_ACK_UP;
        end
      end
      // acknowledge: brief up then brief down
      scfg_pkg::S_ACK_UP:
      begin
        n.motor_up = 1'b1;
        if (halves >= scfg_pkg::JOG_HALVES)
          n.state = scfg_pkg::S_ACK_DOWN;
      end
      scfg_pkg::S_ACK_DOWN:
      begin
        n.motor_down = 1'b1;
        if (halves >= scfg_pkg::JOG_HALVES)
          n.state = scfg_pkg::S_RELEASE;
      end
      // wait for every button to be let go
      scfg_pkg::S_RELEASE:
      begin
        if (b == '0)
          n.state = scfg_pkg::S_IDLE;
      end
    endcase
    restart = (b != st.prev) || (n.state != st.state);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= n;
  end

  // outputs straight from state flops
  assign reg_rdata_out = st.rdata;
  assign nv_wr_out = st.nv_wr;
  assign nv_wr_data_out = st.rec;
  assign motor_up_out = st.motor_up;
  assign motor_down_out = st.motor_down;
  assign auto_adjust_out = st.rec.auto_adj;
  assign rev_obstacle_out = st.rec.rev_obst;
  assign rev_blockage_out = st.rec.rev_block;
  assign comp_out = st.rec.comp;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_obst_hit;
    st.state == scfg_pkg::S_CFG_HOLD && cfg_ok && halves == scfg_pkg::RST_HALVES && !st.tog1;
  endsequence
  sequence s_comp_hit;
    st.state == scfg_pkg::S_CFG_HOLD && cfg_ok && halves == scfg_pkg::COMP_HALVES && !st.tog2;
  endsequence
  sequence s_jog;
    motor_up_out && !motor_down_out;
  endsequence
  sequence s_down_jog;
    st.state == scfg_pkg::S_ACK_DOWN ##1 motor_down_out && !motor_up_out;
  endsequence

  AST_DEFAULTS: assert property (
    (st.state == scfg_pkg::S_RST_HOLD && rst_ok && halves >= scfg_pkg::RST_HALVES)
    |=> !st.rec.upper_valid && !st.rec.lower_valid && auto_adjust_out && rev_obstacle_out
        && rev_blockage_out && comp_out && nv_wr_out)
    else $error("factory defaults not loaded");
  AST_ACK_ORDER: assert property (
    (st.state == scfg_pkg::S_ACK_UP && halves >= scfg_pkg::JOG_HALVES) |-> ##1 s_down_jog)
    else $error("acknowledge down jog missing");
  AST_OBST_TOG: assert property (
    s_obst_hit |=> rev_obstacle_out != $past(rev_obstacle_out))
    else $error("reversing setting not toggled");
  AST_OBST_JOG: assert property (
    s_obst_hit |=> s_jog)
    else $error("reversing toggle not confirmed");
  AST_COMP_TOG: assert property (
    s_comp_hit |=> comp_out != $past(comp_out))
    else $error("compensation setting not toggled");
  AST_COMP_JOG: assert property (
    s_comp_hit |=> s_jog)
    else $error("compensation toggle not confirmed");
  AST_UP_STOP: assert property (
    (st.state == scfg_pkg::S_IDLE && no_prog && b.up && !b.down && !rst_ok)
    |=> motor_up_out == !$past(at_upper))
    else $error("up drive ignores upper end point");
  AST_EP_STORE: assert property (
    (st.state == scfg_pkg::S_EP_RUN && !b.up && !b.down && st.primary_up)
    |=> st.rec.upper_valid && st.rec.upper_pos == $past(pos_in) && !motor_up_out)
    else $error("upper end point not stored on release");
  AST_ABORT: assert property (
    (st.state == scfg_pkg::S_ARM && !prim)
    |=> st.state == scfg_pkg::S_RELEASE && $stable(st.rec))
    else $error("broken pattern not aborted cleanly");
  AST_RESTART: assert property (
    restart |=> halves == 8'h00)
    else $error("hold timer not restarted");
endmodule : shutter_cfg_ctrl
`default_nettype wire

// *** tb_motor_button_sequence_config.sv ***
/*
  Self-checking bench of the configuration interpreter: register table,
  toggles, factory resets, end point programming and aborts.
  Assumes the design package and operator model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_motor_button_sequence_config;
  localparam int unsigned H = 4;
  typedef struct {logic wr; logic [1:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_t;
  logic clk_in = 1'b0;
  logic nrst_in;
  scfg_pkg::btn_t btn;
  logic [15:0] pos_in;
  scfg_pkg::nv_rec_t nv_rd_in;
  scfg_pkg::reg_req_t reg_in;
  logic [15:0] reg_rdata_out;
  logic nv_wr_out;
  scfg_pkg::nv_rec_t nv_data;
  logic motor_up_out;
  logic motor_down_out;
  logic auto_adjust_out;
  logic rev_obstacle_out;
  logic rev_blockage_out;
  logic comp_out;
  logic stuck;
  logic up_q = 1'b0;
  logic dn_q = 1'b0;
  logic [15:0] seq = 16'h0000;
  logic [15:0] nv_cnt = 16'h0000;
  logic [15:0] n0;
  int num_errors = 0;
  int tests_run = 0;
  row_t rows [7] = '{
    '{1'b0, 2'h0, 16'h0000, 16'h0005}, '{1'b0, 2'h1, 16'h0000, 16'h0003},
    '{1'b0, 2'h2, 16'h0000, 16'h0100}, '{1'b0, 2'h3, 16'h0000, 16'h0010},
    '{1'b1, 2'h0, 16'h000A, 16'h000A}, '{1'b1, 2'h2, 16'h0777, 16'h0100},
    '{1'b1, 2'h0, 16'h0000, 16'h0000}};

  // 125 MHz clock
  always #4 clk_in = ~clk_in;

  shutter_cfg_ctrl #(.HALF_CYC(H)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .btn_in(btn),
    .pos_in(pos_in), .nv_rd_in(nv_rd_in), .reg_in(reg_in), .reg_rdata_out(reg_rdata_out),
    .nv_wr_out(nv_wr_out), .nv_wr_data_out(nv_data), .motor_up_out(motor_up_out),
    .motor_down_out(motor_down_out), .auto_adjust_out(auto_adjust_out),
    .rev_obstacle_out(rev_obstacle_out), .rev_blockage_out(rev_blockage_out),
    .comp_out(comp_out));

  scfg_operator #(.HALF_CYC(H)) i_op (.clk_in(clk_in), .motor_up_in(motor_up_out),
    .motor_down_in(motor_down_out), .btn_out(btn), .stuck_out(stuck));

  task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check_val

  task automatic check_set(input logic [3:0] e);
    #1 check_val("settings", {12'h000, e},
      {12'h000, comp_out, rev_blockage_out, rev_obstacle_out, auto_adjust_out});
  endtask : check_set

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    reg_in <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : reg_wr

  task automatic reg_chk(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_in);
    reg_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    reg_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    #1 check_val("register", e, reg_rdata_out);
  endtask : reg_chk

  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // record jog starts as 2-bit codes and count store writes
  always @(posedge clk_in)
  begin
    up_q <= motor_up_out;
    dn_q <= motor_down_out;
    if (motor_up_out === 1'b1 && up_q === 1'b0)
      seq <= {seq[13:0], 2'h1};
    if (motor_down_out === 1'b1 && dn_q === 1'b0)
      seq <= {seq[13:0], 2'h2};
    if (nv_wr_out === 1'b1)
      nv_cnt <= nv_cnt + 16'h0001;
    if (motor_up_out === 1'b1 && motor_down_out === 1'b1)
      check_val("both_motors", 16'h0000, 16'h0001);
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    finish_test();
  end

  // main sequence
  initial
  begin
    nrst_in = 1'b0;
    reg_in = '0;
    pos_in = 16'h0000;
    nv_rd_in = '{upper_pos: 16'h0100, lower_pos: 16'h0010, upper_valid: 1'b1,
      lower_valid: 1'b1, comp: 1'b0, rev_block: 1'b1, rev_obst: 1'b0, auto_adj: 1'b1};
    repeat (16) @(posedge clk_in);
    check_val("motor_in_reset", 16'h0000, {14'h0000, motor_up_out, motor_down_out});
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        reg_wr(rows[i].addr, rows[i].wdata);
      reg_chk(rows[i].addr, rows[i].exp);
    end
    // cord button plus up: reversing at 20 halves, compensation at 40
    seq = 16'h0000;
    i_op.hold(4'h4, 1);
    i_op.hold(4'h6, 30);
    check_set(4'h2);
    i_op.hold(4'h6, 12);
    check_set(4'hA);
    i_op.hold(4'h0, 2);
    check_val("jogs", 16'h0005, seq);
    // three-button factory reset
    seq = 16'h0000;
    n0 = nv_cnt;
    i_op.factory_hold(24);
    check_val("jogs", 16'h0006, seq);
    check_set(4'hF);
    check_val("store_writes", n0 + 16'h0001, nv_cnt);
    reg_chk(scfg_pkg::REG_STATUS, 16'h0000);
    pos_in <= 16'h0050;
    i_op.hold(4'h2, 2);
    check_val("motor_up", 16'h0001, {15'h0000, motor_up_out});
    i_op.hold(4'h0, 2);
    // upper end point by pulses on down
    pos_in <= 16'h0040;
    i_op.ep_prog(4'h2, 4'h1, 2, 4);
    check_val("motor_up", 16'h0001, {15'h0000, motor_up_out});
    pos_in <= 16'h0123;
    i_op.hold(4'h0, 2);
    check_val("motor_up", 16'h0000, {15'h0000, motor_up_out});
    reg_chk(scfg_pkg::REG_UPPER, 16'h0123);
    check_val("store_upper", 16'h0123, nv_data.upper_pos);
    reg_chk(scfg_pkg::REG_STATUS, 16'h0001);
    i_op.hold(4'h2, 2);
    check_val("motor_up", 16'h0000, {15'h0000, motor_up_out});
    i_op.hold(4'h0, 2);
    // lower end point by pulses on up
    pos_in <= 16'h0030;
    i_op.ep_prog(4'h1, 4'h2, 2, 4);
    check_val("motor_down", 16'h0001, {15'h0000, motor_down_out});
    reg_chk(scfg_pkg::REG_STATUS, 16'h0019);
    pos_in <= 16'h0020;
    i_op.hold(4'h0, 2);
    reg_chk(scfg_pkg::REG_LOWER, 16'h0020);
    reg_chk(scfg_pkg::REG_STATUS, 16'h0003);
    // six-press reset at the lower end
    reg_wr(scfg_pkg::REG_SETTINGS, 16'h0000);
    pos_in <= 16'h0010;
    seq = 16'h0000;
    i_op.ep_prog(4'h1, 4'h2, 5, 6);
    i_op.hold(4'h0, 2);
    check_val("jogs", 16'h0006, seq);
    check_set(4'hF);
    reg_chk(scfg_pkg::REG_STATUS, 16'h0000);
    // broken patterns leave everything unchanged
    n0 = nv_cnt;
    i_op.hold(4'h4, 1);
    i_op.hold(4'h5, 5);
    i_op.hold(4'h0, 2);
    i_op.hold(4'h2, 1);
    i_op.hold(4'h3, 3);
    i_op.hold(4'h0, 2);
    // primary released in the middle of the pulse pattern
    i_op.hold(4'h2, 1);
    i_op.hold(4'h3, 1);
    i_op.hold(4'h1, 2);
    i_op.hold(4'h0, 2);
    check_set(4'hF);
    check_val("store_writes", n0, nv_cnt);
    reg_chk(scfg_pkg::REG_STATUS, 16'h0000);
    if (stuck !== 1'b0)
      num_errors++;
    finish_test();
  end
endmodule : tb_motor_button_sequence_config
`default_nettype wire
